// [hw/slw_defines.svh]
// constants of the split-line serial target and its host end
`ifndef SLW_DEFINES_SVH
`define SLW_DEFINES_SVH
`define SLW_CLK_HZ 100000000
`define SLW_SCL_LOSS_MS 2000
`define SLW_OSC_LOSS_MS 20
`define SLW_SCL_LOSS_CYC ((`SLW_CLK_HZ / 1000) * `SLW_SCL_LOSS_MS)
`define SLW_OSC_LOSS_CYC ((`SLW_CLK_HZ / 1000) * `SLW_OSC_LOSS_MS)
`define SLW_POR_CYC 32'h0000_0100
`define SLW_ADDR_LSB 1
`define SLW_ADDR_MSB 5
`define SLW_SEL_LSB 3
`define SLW_SEL_MSB 6
`define SLW_SEL_COMMON_CTRL 4'h1
`define SLW_SEL_PORT_LSB 0
`define SLW_SEL_PORT_MSB 1
`define SLW_SWRST_BIT 7
// host quarter-bit is this count plus one: 50 cycles, a 500 kHz link clock
`define SLW_HALF_DIV 16'h0031
`endif

// [hw/slw_pkg.sv]
// types shared by both ends of the split-line serial link
package slw_pkg;
	typedef enum logic [2:0] {
		SLW_IDLE = 3'b000,
		SLW_ADDR = 3'b001,
		SLW_SEL = 3'b010,
		SLW_WDATA = 3'b011,
		SLW_RDATA = 3'b100,
		SLW_ACK = 3'b101,
		SLW_IGNORE = 3'b110
	} slw_state_type;
	typedef enum logic [2:0] {
		SLH_IDLE = 3'b000,
		SLH_START = 3'b001,
		SLH_BIT = 3'b010,
		SLH_STOP = 3'b011,
		SLH_DONE = 3'b100
	} slh_state_type;
endpackage : slw_pkg

// [hw/slw_link_if.sv]
// split data line link between host and target
`timescale 1ns/1ns
`default_nettype none
interface slw_link_if;
	logic scl;
	logic sda_host;
	logic sda_target_oe_n;
	logic sda_target;
	modport host (output scl, output sda_host, input sda_target, input sda_target_oe_n);
	modport target (input scl, input sda_host, output sda_target, output sda_target_oe_n);
endinterface : slw_link_if
`default_nettype wire

// [hw/slw_wdog.sv]
// loss-of-activity counter used for both watchdogs
`timescale 1ns/1ns
`default_nettype none
module slw_wdog #(
	parameter int unsigned LIMIT = 16
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic activity_in,
	output logic expired_out
);
	typedef struct packed {
		logic [31:0] count;
		logic expired;
	} slw_wdog_st_type;
	slw_wdog_st_type st;
	slw_wdog_st_type next_st;
	always_comb begin
		next_st = st;
		if (!enable_in || activity_in) begin
			next_st.count = 32'h0000_0000;
		end else if (st.count < 32'(LIMIT)) begin
			next_st.count = st.count + 32'h0000_0001;
		end else begin
			next_st.expired = 1'b1;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign expired_out = st.expired;
endmodule : slw_wdog
`default_nettype wire

// [hw/slw_target.sv]
// serial target end with split data line and clock/oscillator watchdogs
`include "slw_defines.svh"
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Operation
// - input data line separate from output line
// - target only, clock is input
// - read: select write, stop, then read
// - write: address, select, data, one frame
// - held in reset until supplies, timer
// - start/stop are data edges, clock high
// - byte receiver generates acknowledge
// - ignore two msbs, compare five, lsb direction
// - ack low through ninth clock high
// - latch select on eighth falling edge, ack
// - latch data byte, then ack
// - common writes all ports; port writes one
// - host ends transfer with stop
// - read data shifted out msb first
// - host nacks read byte, then stops
// - monitor osc always; clock only host-managed
// - two seconds clock silence disables ports
// - clock trip cleared only by resets
// - oscillator missing 20 ms disables ports
// - defeat pin suppresses both watchdogs
// - host-managed trip asserts interrupt
// - select bits 6..3, code 0001 common control
module slw_target import slw_pkg::*; #(
	parameter int unsigned SCL_LOSS_CYC = `SLW_SCL_LOSS_CYC,
	parameter int unsigned OSC_LOSS_CYC = `SLW_OSC_LOSS_CYC,
	parameter int unsigned POR_CYC = `SLW_POR_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	slw_link_if.target link,
	input wire logic [4:0] target_addr_pins_in,
	input wire logic watchdog_defeat_pin_in,
	input wire logic external_reset_n_pin_in,
	input wire logic supplies_valid_in,
	input wire logic osc_tick_in,
	input wire logic host_managed_mode_in,
	input wire logic [7:0] read_data_in,
	output logic [3:0] reg_sel_out,
	output logic [1:0] port_sel_out,
	output logic [7:0] write_data_out,
	output logic [3:0] write_port_mask_out,
	output logic write_strobe_out,
	output logic ports_disable_out,
	output logic interrupt_n_out
);
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] osc_s;
		logic [1:0] external_reset_n_pin_s;
		logic [1:0] sup_s;
		logic [1:0] wdd_s;
		logic [4:0] pins_s0;
		logic [4:0] pins_s1;
		logic scl_d;
		logic sda_d;
		logic osc_d;
		logic [31:0] por_cnt;
		logic ready;
		slw_state_type state;
		slw_state_type after_ack;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic [7:0] sel;
		logic drive_n;
		logic [7:0] wdata;
		logic [3:0] wmask;
		logic wstb;
		logic ports_off;
		logic intr_n;
	} slw_tgt_st_type;
	slw_tgt_st_type st;
	slw_tgt_st_type next_st;
	logic scl_rise, scl_fall, start_ev, stop_ev, osc_edge, scl_exp, osc_exp, swrst;
	function automatic logic [3:0] port_mask(input logic [7:0] sel);
		if (sel[`SLW_SEL_MSB:`SLW_SEL_LSB] == `SLW_SEL_COMMON_CTRL) begin
			port_mask = 4'hF;
		end else begin
			port_mask = 4'h1 << sel[`SLW_SEL_PORT_MSB:`SLW_SEL_PORT_LSB];
		end
	endfunction : port_mask
	assign scl_rise = st.scl_s[1] && !st.scl_d;
	assign scl_fall = !st.scl_s[1] && st.scl_d;
	assign start_ev = st.scl_s[1] && st.scl_d && st.sda_d && !st.sda_s[1];
	assign stop_ev = st.scl_s[1] && st.scl_d && !st.sda_d && st.sda_s[1];
	assign osc_edge = st.osc_s[1] != st.osc_d;
	assign swrst = st.wstb && st.wdata[`SLW_SWRST_BIT] && (st.wmask == 4'hF);
	////////////////////////////////////////////////////////////////////////////////
	// watchdogs: a clock trip is cleared by reset pin, power reset or software reset; an oscillator trip by reset pin or power reset only
	slw_wdog #(.LIMIT(SCL_LOSS_CYC)) u_scl_wdog (
		.core_clk_in(core_clk_in),
		.rst_in(!st.ready || swrst),
		.enable_in(host_managed_mode_in && !st.wdd_s[1]),
		.activity_in(scl_rise || scl_fall),
		.expired_out(scl_exp)
	);
	slw_wdog #(.LIMIT(OSC_LOSS_CYC)) u_osc_wdog (
		.core_clk_in(core_clk_in),
		.rst_in(!st.ready),
		.enable_in(!st.wdd_s[1]),
		.activity_in(osc_edge),
		.expired_out(osc_exp)
	);
	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.scl_s = {st.scl_s[0], link.scl};
		next_st.sda_s = {st.sda_s[0], link.sda_host};
		next_st.osc_s = {st.osc_s[0], osc_tick_in};
		next_st.external_reset_n_pin_s = {st.external_reset_n_pin_s[0], external_reset_n_pin_in};
		next_st.sup_s = {st.sup_s[0], supplies_valid_in};
		next_st.wdd_s = {st.wdd_s[0], watchdog_defeat_pin_in};
		next_st.pins_s0 = target_addr_pins_in;
		next_st.pins_s1 = st.pins_s0;
		next_st.scl_d = st.scl_s[1];
		next_st.sda_d = st.sda_s[1];
		next_st.osc_d = st.osc_s[1];
		next_st.wstb = 1'b0;
		// supplies and pin reset restart the power-on timer; logic idles meanwhile
		if (!st.sup_s[1] || !st.external_reset_n_pin_s[1]) begin
			next_st.por_cnt = 32'h0000_0000;
			next_st.ready = 1'b0;
		end else if (st.por_cnt < POR_CYC) begin
			next_st.por_cnt = st.por_cnt + 32'h0000_0001;
		end else begin
			next_st.ready = 1'b1;
		end
		next_st.ports_off = (scl_exp || osc_exp) && !st.wdd_s[1];
		next_st.intr_n = !(next_st.ports_off && host_managed_mode_in);
		if (!st.ready) begin
			next_st.state = SLW_IDLE;
			next_st.drive_n = 1'b1;
			next_st.ports_off = 1'b0;
			next_st.intr_n = 1'b1;
		end else if (start_ev) begin
			next_st.state = SLW_ADDR;
			next_st.bitn = 4'h0;
			next_st.drive_n = 1'b1;
		end else if (stop_ev) begin
			next_st.state = SLW_IDLE;
			next_st.drive_n = 1'b1;
		end else begin
			case (st.state)
				SLW_ADDR, SLW_SEL, SLW_WDATA: begin
					if (scl_rise) begin
						next_st.shreg = {st.shreg[6:0], st.sda_s[1]};
						next_st.bitn = st.bitn + 4'h1;
					end else if (scl_fall && st.bitn == 4'h8) begin
						next_st.bitn = 4'h0;
						next_st.state = SLW_ACK;
						next_st.drive_n = 1'b0;
						if (st.state == SLW_ADDR) begin
							if (st.shreg[`SLW_ADDR_MSB:`SLW_ADDR_LSB] != st.pins_s1) begin
								next_st.state = SLW_IGNORE;
								next_st.drive_n = 1'b1;
							end else if (st.shreg[0]) begin
								next_st.after_ack = SLW_RDATA;
							end else begin
								next_st.after_ack = SLW_SEL;
							end
						end else if (st.state == SLW_SEL) begin
							next_st.sel = st.shreg;
							next_st.after_ack = SLW_WDATA;
						end else begin
							next_st.wdata = st.shreg;
							next_st.wmask = port_mask(st.sel);
							next_st.wstb = 1'b1;
							next_st.after_ack = SLW_IGNORE;
						end
					end
				end
				SLW_ACK: begin
					if (scl_fall) begin
						next_st.state = st.after_ack;
						next_st.drive_n = 1'b1;
						if (st.after_ack == SLW_RDATA) begin
							next_st.shreg = {read_data_in[6:0], 1'b0};
							next_st.drive_n = read_data_in[7];
							next_st.bitn = 4'h1;
						end
					end
				end
				SLW_RDATA: begin
					if (scl_fall) begin
						if (st.bitn == 4'h8) begin
							next_st.drive_n = 1'b1;
							next_st.state = SLW_IGNORE;
						end else begin
							next_st.drive_n = st.shreg[7];
							next_st.shreg = {st.shreg[6:0], 1'b0};
							next_st.bitn = st.bitn + 4'h1;
						end
					end
				end
				SLW_IDLE, SLW_IGNORE: begin
					next_st.drive_n = 1'b1;
				end
				default: begin
					next_st.state = SLW_IDLE;
					next_st.drive_n = 1'b1;
				end
			endcase
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st <= '0;
			st.scl_s <= 2'h3;
			st.sda_s <= 2'h3;
			st.scl_d <= 1'b1;
			st.sda_d <= 1'b1;
			st.drive_n <= 1'b1;
			st.intr_n <= 1'b1;
			st.state <= SLW_IDLE;
		end else begin
			st <= next_st;
		end
	end
	// released line drives high so a tie of both lines still works
	assign link.sda_target = st.drive_n;
	assign link.sda_target_oe_n = st.drive_n;
	assign reg_sel_out = st.sel[`SLW_SEL_MSB:`SLW_SEL_LSB];
	assign port_sel_out = st.sel[`SLW_SEL_PORT_MSB:`SLW_SEL_PORT_LSB];
	assign write_data_out = st.wdata;
	assign write_port_mask_out = st.wmask;
	assign write_strobe_out = st.wstb;
	assign ports_disable_out = st.ports_off;
	assign interrupt_n_out = st.intr_n;
endmodule : slw_target
`default_nettype wire

// [hw/slw_host.sv]
// host end: issues 3-byte writes and 4-byte split reads
`include "slw_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module slw_host import slw_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rst_in,
	slw_link_if.host link,
	input wire logic req_in,
	input wire logic req_read_in,
	input wire logic [4:0] req_addr_in,
	input wire logic [7:0] req_sel_in,
	input wire logic [7:0] req_data_in,
	output logic busy_out,
	output logic done_out,
	output logic nack_out,
	output logic [7:0] rdata_out
);
	typedef struct packed {
		logic [15:0] div;
		logic [1:0] ph;
		slh_state_type state;
		logic [1:0] sda_s;
		logic [3:0] bitn;
		logic [1:0] byten;
		logic [1:0] nbytes;
		logic second;
		logic [7:0] tx;
		logic [7:0] rx;
		logic scl;
		logic sda;
		logic rd;
		logic [4:0] addr;
		logic [7:0] sel;
		logic [7:0] data;
		logic busy;
		logic done;
		logic nack;
	} slh_st_type;
	slh_st_type st;
	slh_st_type next_st;
	logic tick;
	assign tick = (st.div == `SLW_HALF_DIV);
	always_comb begin
		next_st = st;
		next_st.sda_s = {st.sda_s[0], link.sda_target};
		next_st.done = 1'b0;
		next_st.div = tick ? 16'h0000 : st.div + 16'h0001;
		case (st.state)
			SLH_IDLE: begin
				if (req_in) begin
					next_st = st;
					next_st.sda_s = {st.sda_s[0], link.sda_target};
					next_st.done = 1'b0;
					next_st.div = 16'h0000;
					next_st.rd = req_read_in;
					next_st.addr = req_addr_in;
					next_st.sel = req_sel_in;
					next_st.data = req_data_in;
					next_st.second = 1'b0;
					next_st.nbytes = 2'h3;
					next_st.busy = 1'b1;
					next_st.nack = 1'b0;
					next_st.state = SLH_START;
				end
			end
			SLH_START: begin
				if (tick) begin
					next_st.sda = 1'b0;
					next_st.tx = {2'b00, st.addr, st.second};
					next_st.bitn = 4'h0;
					next_st.byten = 2'h0;
					next_st.ph = 2'h0;
					next_st.nbytes = st.second ? 2'h2 : (st.rd ? 2'h2 : 2'h3);
					next_st.state = SLH_BIT;
				end
			end
			SLH_BIT: begin
				if (tick) begin
					next_st.ph = st.ph + 2'h1;
					if (st.ph == 2'h0) begin
						next_st.scl = 1'b0;
					end else if (st.ph == 2'h1) begin
						// release on ack slots and read data; the read nack is high as well
						if (st.bitn == 4'h8) begin
							next_st.sda = 1'b1;
						end else if (st.second && st.byten == 2'h1) begin
							next_st.sda = 1'b1;
						end else begin
							next_st.sda = st.tx[7];
							next_st.tx = {st.tx[6:0], 1'b0};
						end
					end else if (st.ph == 2'h2) begin
						next_st.scl = 1'b1;
					end else begin
						if (st.bitn == 4'h8) begin
							next_st.bitn = 4'h0;
							if (!(st.second && st.byten == 2'h1) && st.sda_s[1]) begin
								next_st.nack = 1'b1;
								next_st.state = SLH_STOP;
							end else if (st.byten + 2'h1 == st.nbytes) begin
								next_st.state = SLH_STOP;
							end else begin
								next_st.byten = st.byten + 2'h1;
								next_st.tx = (st.byten == 2'h0) ? st.sel : st.data;
							end
						end else begin
							next_st.bitn = st.bitn + 4'h1;
							if (st.second && st.byten == 2'h1) begin
								next_st.rx = {st.rx[6:0], st.sda_s[1]};
							end
						end
					end
				end
			end
			SLH_STOP: begin
				if (tick) begin
					next_st.ph = st.ph + 2'h1;
					if (st.ph == 2'h0) begin
						next_st.scl = 1'b0;
					end else if (st.ph == 2'h1) begin
						next_st.sda = 1'b0;
					end else if (st.ph == 2'h2) begin
						next_st.scl = 1'b1;
					end else begin
						next_st.sda = 1'b1;
						next_st.state = (st.rd && !st.second && !st.nack) ? SLH_START : SLH_DONE;
						next_st.second = 1'b1;
					end
				end
			end
			SLH_DONE: begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.state = SLH_IDLE;
			end
			default: begin
				next_st.state = SLH_IDLE;
			end
		endcase
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st <= '0;
			st.scl <= 1'b1;
			st.sda <= 1'b1;
			st.sda_s <= 2'h3;
			st.state <= SLH_IDLE;
		end else begin
			st <= next_st;
		end
	end
	assign link.scl = st.scl;
	assign link.sda_host = st.sda;
	assign busy_out = st.busy;
	assign done_out = st.done;
	assign nack_out = st.nack;
	assign rdata_out = st.rx;
endmodule : slw_host
`default_nettype wire

// [verif/slw_link_asserts.sv]
// concurrent checks on the split-line serial link
`timescale 1ns/1ns
`default_nettype none
module slw_link_asserts (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic scl,
	input wire logic sda_host,
	input wire logic sda_target,
	input wire logic sda_target_oe_n
);
	logic ps;
	logic psda;
	logic rd;
	logic [5:0] nrise;
	logic hi;
	assign hi = scl && ps;
	// rises counted per frame; the stop rise is counted too, so it lands one past a byte
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ps <= 1'b1;
			psda <= 1'b1;
			rd <= 1'b0;
			nrise <= 6'h00;
		end else begin
			ps <= scl;
			psda <= sda_host;
			if (hi && psda && !sda_host) begin
				rd <= 1'b0;
				nrise <= 6'h00;
			end else if (scl && !ps) begin
				nrise <= nrise + 6'h01;
				if (nrise == 6'h07) begin
					rd <= sda_host;
				end
			end
		end
	end
	////////////////////////////////
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_oe_mirrors_data: assert property (sda_target == sda_target_oe_n)
		else $error("target data differs from its enable");
	a_stable_clock_high: assert property (hi |-> $stable(sda_target_oe_n))
		else $error("target output moved while clock high");
	a_rx_bits_free: assert property (hi && !rd && nrise % 6'h09 != 6'h00 |-> sda_target_oe_n)
		else $error("target drove a bit it receives");
	a_rd_nack_free: assert property (hi && rd && nrise == 6'h12 |-> sda_target_oe_n)
		else $error("target drove the host ack slot");
	a_ack_released: assert property ($fell(scl) && !rd && nrise != 6'h00
		&& nrise % 6'h09 == 6'h00 |-> ##[1:8] sda_target_oe_n)
		else $error("target ack not released after ninth clock");
	a_cond_released: assert property (hi && sda_host != psda |-> sda_target_oe_n)
		else $error("target driving at start or stop");
	a_stop_boundary: assert property (hi && sda_host && !psda
		|-> nrise inside {6'h0A, 6'h13, 6'h1C})
		else $error("stop not on a byte boundary");
	a_host_frees_ack: assert property (hi && sda_host == psda && nrise != 6'h00
		&& nrise % 6'h09 == 6'h00 |-> sda_host)
		else $error("host drove an ack slot low");
endmodule : slw_link_asserts
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench: host end and target end joined by the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] pins = 5'h00;
	logic defeat = 1'b0;
	logic rst_n_pin = 1'b1;
	logic sup = 1'b1;
	logic osc = 1'b0;
	logic osc_run = 1'b1;
	logic hm = 1'b0;
	logic [7:0] rdin = 8'h00;
	logic req = 1'b0;
	logic req_rd = 1'b0;
	logic [4:0] raddr = 5'h00;
	logic [7:0] rsel = 8'h00;
	logic [7:0] rdat = 8'h00;
	logic [3:0] reg_sel;
	logic [1:0] port_sel;
	logic [7:0] wdata;
	logic [3:0] wmask;
	logic wstb, dis, irq_n, busy, done, nack;
	logic [7:0] rdata;
	logic [17:0] wq[$];
	logic [9:0] dq[$];
	int checked = 0;
	int n_mismatch = 0;
	slw_link_if link ();
	slw_host slw_host_inst (.core_clk_in(clk), .rst_in(rst), .link(link.host), .req_in(req),
		.req_read_in(req_rd), .req_addr_in(raddr), .req_sel_in(rsel), .req_data_in(rdat),
		.busy_out(busy), .done_out(done), .nack_out(nack), .rdata_out(rdata));
	slw_target #(.SCL_LOSS_CYC(2000), .OSC_LOSS_CYC(500), .POR_CYC(16)) slw_target_inst (
		.core_clk_in(clk), .rst_in(rst), .link(link.target), .target_addr_pins_in(pins),
		.watchdog_defeat_pin_in(defeat), .external_reset_n_pin_in(rst_n_pin),
		.supplies_valid_in(sup), .osc_tick_in(osc), .host_managed_mode_in(hm),
		.read_data_in(rdin), .reg_sel_out(reg_sel), .port_sel_out(port_sel),
		.write_data_out(wdata), .write_port_mask_out(wmask), .write_strobe_out(wstb),
		.ports_disable_out(dis), .interrupt_n_out(irq_n));
	slw_link_asserts slw_link_asserts_inst (.core_clk_in(clk), .rst_in(rst), .scl(link.scl),
		.sda_host(link.sda_host), .sda_target(link.sda_target),
		.sda_target_oe_n(link.sda_target_oe_n));
	////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (osc_run) osc <= ~osc;
	end
	initial begin
		#600000;
		n_mismatch++;
		end_sim();
	end
	task automatic end_sim;
		if (wq.size() != 0 || dq.size() != 0) begin
			n_mismatch++;
			$display("BAD leftover results expected 0 seen %0d", wq.size() + dq.size());
		end
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task automatic cmp_wr(input string what, input logic [17:0] e, input logic [17:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_wr
	task automatic cmp_val(input string what, input logic [9:0] e, input logic [9:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_val
	task automatic flags(input logic [1:0] e);
		cmp_val("disable and irq_n", {8'h00, e}, {8'h00, dis, irq_n});
	endtask : flags
	// request held until busy: a pulse landing in the host's done cycle would be lost
	task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] s,
		input logic [7:0] d);
		@(posedge clk);
		req <= 1'b1;
		req_rd <= r;
		raddr <= a;
		rsel <= s;
		rdat <= d;
		repeat (20) if (busy !== 1'b1) @(posedge clk);
		cmp_val("host busy", 10'h001, {9'h000, busy});
		req <= 1'b0;
		repeat (20000) if (done !== 1'b1) @(posedge clk);
		cmp_val("host done", 10'h001, {9'h000, done});
		@(posedge clk);
	endtask : xfer
	////////////////////////////////
	always @(posedge clk) begin
		logic [17:0] we;
		logic [9:0] de;
		if (wstb === 1'b1) begin
			we = (wq.size() != 0) ? wq.pop_front() : 18'hX;
			cmp_wr("write outputs", we, {reg_sel, port_sel, wdata, wmask});
		end
		if (done === 1'b1) begin
			de = (dq.size() != 0) ? dq.pop_front() : 10'hX;
			cmp_val("host result", {1'b0, de[8], de[9] ? de[7:0] : 8'h00},
				{1'b0, nack, de[9] ? rdata : 8'h00});
		end
	end
	initial begin
		logic [1:0] port;
		logic [3:0] code;
		void'($urandom(32'h740984D1));
		@(posedge clk);
		pins <= 5'($urandom);
		rdin <= 8'($urandom);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (40) @(posedge clk);
		flags(2'b01);
		sup <= 1'b0;
		dq.push_back(10'h100);
		xfer(1'b0, pins, 8'h08, 8'h00);
		sup <= 1'b1;
		repeat (40) @(posedge clk);
		port = 2'($urandom);
		code = 4'h4 + 4'($urandom % 10);
		dq.push_back(10'h100);
		xfer(1'b0, pins ^ (5'h01 << ($urandom % 5)), 8'($urandom), 8'($urandom));
		dq.push_back({2'b10, rdin});
		xfer(1'b1, pins, {1'b0, code, 1'b0, port}, 8'h00);
		cmp_val("read select", {4'h0, code, port}, {4'h0, reg_sel, port_sel});
		wq.push_back({4'h2, port, rdin, 4'h1 << port});
		dq.push_back(10'h000);
		xfer(1'b0, pins, {1'b0, 4'h2, 1'b0, port}, rdin);
		defeat <= 1'b1;
		hm <= 1'b1;
		osc_run <= 1'b0;
		repeat (3000) @(posedge clk);
		flags(2'b01);
		osc_run <= 1'b1;
		defeat <= 1'b0;
		repeat (2600) @(posedge clk);
		flags(2'b10);
		hm <= 1'b0;
		repeat (20) @(posedge clk);
		cmp_val("disable held", 10'h001, {9'h000, dis});
		wq.push_back({4'h1, port, 1'b1, rdin[6:0], 4'hF});
		dq.push_back(10'h000);
		xfer(1'b0, pins, {1'b0, 4'h1, 1'b0, port}, {1'b1, rdin[6:0]});
		flags(2'b01);
		repeat (2600) @(posedge clk);
		flags(2'b01);
		osc_run <= 1'b0;
		repeat (700) @(posedge clk);
		flags(2'b11);
		rst_n_pin <= 1'b0;
		osc_run <= 1'b1;
		repeat (10) @(posedge clk);
		rst_n_pin <= 1'b1;
		repeat (60) @(posedge clk);
		flags(2'b01);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
